// ---- design/mbi_defs.svh ----
/*
 * constants for the host-side bus controller: widths, pin positions,
 * timing figures and the cycle counts derived from them.
 * assumes a 10 MHz controller clock.
 */
`ifndef MBI_DEFS_SVH
`define MBI_DEFS_SVH

// widths
`define MBI_ADDR_W      20
`define MBI_DATA_W      8
`define MBI_HI_W        12
`define MBI_TAG_W       16
`define MBI_NIB_W       4
`define MBI_CNT_W       4

// address field positions
`define MBI_LO_MSB      7
`define MBI_HI_LSB      8
`define MBI_PAGE_MSB    15
`define MBI_BURST_MSB   11
`define MBI_TAG_LSB     4
`define MBI_NIB_MSB     3

// clock rate and bus timing
`define MBI_CLK_MHZ     10
`define MBI_ALE_NS      100
`define MBI_HOLD_NS     100
`define MBI_STB_NS      300
`define MBI_REC_NS      100

// cycle counts: least times round up
`define MBI_CYC(ns)     (((ns) * `MBI_CLK_MHZ + 999) / 1000)
`define MBI_ALE_CYC     `MBI_CYC(`MBI_ALE_NS)
`define MBI_HOLD_CYC    `MBI_CYC(`MBI_HOLD_NS)
`define MBI_STB_CYC     `MBI_CYC(`MBI_STB_NS)
`define MBI_REC_CYC     `MBI_CYC(`MBI_REC_NS)

`endif

// ---- design/mbi_pkg.sv ----
/*
 * types for the host-side bus controller: bus modes, sequencer states
 * and the packed state record.
 * assumes mbi_defs.svh is on the include path.
 */
`include "mbi_defs.svh"

package mbi_pkg;

    // how address and data share the pins
    typedef enum logic [1:0] {
        MODE_MUX,
        MODE_PAGE,
        MODE_NONMUX,
        MODE_BURST
    } mbi_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ALE,
        ST_HOLD,
        ST_STB,
        ST_REC
    } mbi_state_e;

    typedef struct packed {
        mbi_state_e                 state;
        logic [`MBI_CNT_W-1:0]      cnt;
        mbi_mode_e                  mode;
        logic                       moto;
        logic                       single;
        logic                       write;
        logic                       fetch;
        logic [`MBI_DATA_W-1:0]     wdata;
        logic [`MBI_TAG_W-1:0]      tag;
        logic                       tagValid;
        mbi_mode_e                  tagMode;
        logic [`MBI_DATA_W-1:0]     ad;
        logic                       adOe;
        logic [`MBI_DATA_W-1:0]     pa;
        logic                       paOe;
        logic [`MBI_DATA_W-1:0]     addrLo;
        logic [`MBI_HI_W-1:0]       addrHi;
        logic                       ale;
        logic                       wrPin;
        logic                       rdPin;
        logic                       fetchPin;
        logic                       ready;
        logic                       rspValid;
        logic [`MBI_DATA_W-1:0]     rdata;
    } mbi_state_s;

endpackage

// ---- design/mbi_host_ctrl.sv ----
/*
 * host-side controller for an 8-bit microcontroller bus peripheral:
 * takes read, write and fetch orders at a user port and plays them out
 * on the multiplexed address/data port, port A and the control pins.
 * assumes the peripheral is configured for the same bus mode and strobe
 * style as the cfg inputs, and that pin inputs are synchronous to mclk.
 */
// Summary of operation
// - non-multiplexed: address on ad port, data port A
// - page mode: hit skips strobe, only low byte
// - multiplexed: low byte muxed, strobe every cycle
// - burst: upper bits held, low nibble steps
// - burst: A11-A4 muxed, A3-A0 on port A
`timescale 1ns/1ps

module mbi_host_ctrl (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rstn,
    // configuration, sampled when an order is taken
    input  wire mbi_pkg::mbi_mode_e      cfgMode,
    input  wire logic                    cfgMoto,
    input  wire logic                    cfgSingleRead,
    // user orders
    input  wire logic                    reqValid,
    input  wire logic                    reqWrite,
    input  wire logic                    reqFetch,
    input  wire logic [`MBI_ADDR_W-1:0]  reqAddr,
    input  wire logic [`MBI_DATA_W-1:0]  reqWdata,
    output logic                         reqReady,
    output logic                         rspValid,
    output logic [`MBI_DATA_W-1:0]       rspRdata,
    // address/data port
    input  wire logic [`MBI_DATA_W-1:0]  addrDataIn,
    output logic [`MBI_DATA_W-1:0]       addrDataOut,
    output logic                         addrDataOe,
    // port A
    input  wire logic [`MBI_DATA_W-1:0]  portAIn,
    output logic [`MBI_DATA_W-1:0]       portAOut,
    output logic                         portAOe,
    // plain address lines
    output logic [`MBI_DATA_W-1:0]       addrLoOut,
    output logic [`MBI_HI_W-1:0]         addrHiOut,
    // control pins
    output logic                         addrLatchStrobe,
    output logic                         writeCtrlPin,
    output logic                         readCtrlPin,
    output logic                         fetchCtrlPin
);

    mbi_pkg::mbi_state_s st_q;
    mbi_pkg::mbi_state_s st_d;
    logic                pageHit;
    logic                burstHit;

    // page and burst hits compare against the last latched address
    always_comb begin
        pageHit  = st_q.tagValid && (st_q.tagMode == mbi_pkg::MODE_PAGE)
                   && (cfgMode == mbi_pkg::MODE_PAGE)
                   && (reqAddr[`MBI_ADDR_W-1:`MBI_HI_LSB]
                       == st_q.tag[`MBI_TAG_W-1:`MBI_HI_LSB-`MBI_TAG_LSB]);
        burstHit = st_q.tagValid && (st_q.tagMode == mbi_pkg::MODE_BURST)
                   && (cfgMode == mbi_pkg::MODE_BURST)
                   && (reqAddr[`MBI_ADDR_W-1:`MBI_TAG_LSB] == st_q.tag);
    end

    // sequencer: address phase, latch hold, strobe, recovery
    always_comb begin
        st_d          = st_q;
        st_d.rspValid = 1'b0;
        case (st_q.state)
            mbi_pkg::ST_IDLE: begin
                if (reqValid) begin
                    st_d.ready  = 1'b0;
                    st_d.mode   = cfgMode;
                    st_d.moto   = cfgMoto;
                    st_d.single = cfgSingleRead;
                    st_d.write  = reqWrite;
                    st_d.fetch  = reqFetch & ~reqWrite;
                    st_d.wdata  = reqWdata;
                    // non-multiplexed lines carry the full address
                    st_d.addrLo = reqAddr[`MBI_LO_MSB:0];
                    st_d.addrHi = reqAddr[`MBI_ADDR_W-1:`MBI_HI_LSB];
                    // direction line settles before the enable strobe
                    st_d.wrPin  = cfgMoto ? ~reqWrite : 1'b1;
                    st_d.paOe   = 1'b0;
                    if (cfgMode == mbi_pkg::MODE_BURST) begin
                        // low nibble travels apart on port A
                        st_d.pa   = {{(`MBI_DATA_W-`MBI_NIB_W){1'b0}}, reqAddr[`MBI_NIB_MSB:0]};
                        st_d.paOe = 1'b1;
                    end
                    if (cfgMode == mbi_pkg::MODE_NONMUX) begin
                        // address stays on the ad port, no latch strobe
                        st_d.ad    = reqAddr[`MBI_LO_MSB:0];
                        st_d.adOe  = 1'b1;
                        st_d.state = mbi_pkg::ST_HOLD;
                        st_d.cnt   = `MBI_CNT_W'(`MBI_HOLD_CYC - 1);
                    end else if (pageHit || burstHit) begin
                        // held upper address reused, only low bits move
                        st_d.adOe  = 1'b0;
                        st_d.state = mbi_pkg::ST_HOLD;
                        st_d.cnt   = `MBI_CNT_W'(`MBI_HOLD_CYC - 1);
                    end else begin
                        if (cfgMode == mbi_pkg::MODE_PAGE) begin
                            st_d.ad = reqAddr[`MBI_PAGE_MSB:`MBI_HI_LSB];
                        end else if (cfgMode == mbi_pkg::MODE_BURST) begin
                            st_d.ad = reqAddr[`MBI_BURST_MSB:`MBI_TAG_LSB];
                        end else begin
                            st_d.ad = reqAddr[`MBI_LO_MSB:0];
                        end
                        // every miss raises the latch strobe
                        st_d.adOe     = 1'b1;
                        st_d.ale      = 1'b1;
                        st_d.tag      = reqAddr[`MBI_ADDR_W-1:`MBI_TAG_LSB];
                        st_d.tagValid = 1'b1;
                        st_d.tagMode  = cfgMode;
                        st_d.state    = mbi_pkg::ST_ALE;
                        st_d.cnt      = `MBI_CNT_W'(`MBI_ALE_CYC - 1);
                    end
                end
            end
            mbi_pkg::ST_ALE: begin
                if (st_q.cnt != '0) begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end else begin
                    // falling strobe latches; address held past it
                    st_d.ale   = 1'b0;
                    st_d.state = mbi_pkg::ST_HOLD;
                    st_d.cnt   = `MBI_CNT_W'(`MBI_HOLD_CYC - 1);
                end
            end
            mbi_pkg::ST_HOLD: begin
                if (st_q.cnt != '0) begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end else begin
                    st_d.state = mbi_pkg::ST_STB;
                    st_d.cnt   = `MBI_CNT_W'(`MBI_STB_CYC - 1);
                    if (st_q.mode == mbi_pkg::MODE_NONMUX) begin
                        // data bytes move over port A
                        st_d.pa   = st_q.wdata;
                        st_d.paOe = st_q.write;
                    end else begin
                        // drive write data on the port, or release it so the device may answer a read
                        st_d.ad   = st_q.wdata;
                        st_d.adOe = st_q.write;
                    end
                    if (st_q.moto) begin
                        st_d.rdPin = 1'b1;                    // enable strobe
                    end else if (st_q.write) begin
                        st_d.wrPin = 1'b0;
                    end else if (st_q.fetch && !st_q.single) begin
                        st_d.fetchPin = 1'b0;
                    end else begin
                        st_d.rdPin = 1'b0;
                    end
                end
            end
            mbi_pkg::ST_STB: begin
                if (st_q.cnt != '0) begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end else begin
                    // sample read data before the strobe ends
                    if (!st_q.write) begin
                        st_d.rdata = (st_q.mode == mbi_pkg::MODE_NONMUX) ? portAIn : addrDataIn;
                    end
                    st_d.wrPin    = st_q.moto ? st_q.wrPin : 1'b1;
                    st_d.rdPin    = ~st_q.moto;
                    st_d.fetchPin = 1'b1;
                    st_d.state    = mbi_pkg::ST_REC;
                    st_d.cnt      = `MBI_CNT_W'(`MBI_REC_CYC - 1);
                end
            end
            mbi_pkg::ST_REC: begin
                if (st_q.cnt != '0) begin
                    st_d.cnt = st_q.cnt - 1'b1;
                end else begin
                    // write data held through recovery, then released
                    st_d.adOe     = (st_q.mode == mbi_pkg::MODE_NONMUX);
                    st_d.paOe     = (st_q.mode == mbi_pkg::MODE_BURST);
                    st_d.wrPin    = 1'b1;    // write strobe idle, or direction back to read
                    st_d.rspValid = 1'b1;
                    st_d.ready    = 1'b1;
                    st_d.state    = mbi_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d.state = mbi_pkg::ST_IDLE;
            end
        endcase
    end

    // state register; strobes idle inactive for separate-strobe hosts
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q          <= '0;
            st_q.state    <= mbi_pkg::ST_IDLE;
            st_q.wrPin    <= 1'b1;
            st_q.rdPin    <= 1'b1;
            st_q.fetchPin <= 1'b1;
            st_q.ready    <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign reqReady        = st_q.ready;
    assign rspValid        = st_q.rspValid;
    assign rspRdata        = st_q.rdata;
    assign addrDataOut     = st_q.ad;
    assign addrDataOe      = st_q.adOe;
    assign portAOut        = st_q.pa;
    assign portAOe         = st_q.paOe;
    assign addrLoOut       = st_q.addrLo;
    assign addrHiOut       = st_q.addrHi;
    assign addrLatchStrobe = st_q.ale;
    assign writeCtrlPin    = st_q.wrPin;
    assign readCtrlPin     = st_q.rdPin;
    assign fetchCtrlPin    = st_q.fetchPin;

endmodule

// ---- verif/mbi_chk_assertions.sv ----
/* assertions on the controller pins: strobe widths, latency, address phase.
   assumes cfg inputs hold still while an order is in flight. */
`timescale 1ns/1ps
module mbi_chk (
    // clock, reset, configuration
    input wire logic               mclk,
    input wire logic               rstn,
    input wire mbi_pkg::mbi_mode_e cfgMode,
    input wire logic               cfgMoto,
    input wire logic               cfgSingleRead,
    // order handshake
    input wire logic               reqValid,
    input wire logic               reqReady,
    input wire logic               rspValid,
    // bus pins
    input wire logic [7:0]         addrDataOut,
    input wire logic               addrDataOe,
    input wire logic [7:0]         portAOut,
    input wire logic               portAOe,
    input wire logic [7:0]         addrLoOut,
    input wire logic [11:0]        addrHiOut,
    input wire logic               addrLatchStrobe,
    input wire logic               writeCtrlPin,
    input wire logic               readCtrlPin,
    input wire logic               fetchCtrlPin
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // an order is taken when both handshake lines are high
    wire logic take = reqValid && reqReady;
    wire logic sep  = !cfgMoto;
    rsp_window_a: assert property (take |=> !rspValid[*4] ##[2:3] rspValid)
        else $error("answer outside its window");
    ale_pulse_a: assert property (addrLatchStrobe |=> !addrLatchStrobe) else $error("latch strobe too long");
    mux_low_a: assert property (addrLatchStrobe && cfgMode == mbi_pkg::MODE_MUX |->
        addrDataOe && addrDataOut == addrLoOut) else $error("mux address phase wrong");
    page_high_a: assert property (addrLatchStrobe && cfgMode == mbi_pkg::MODE_PAGE |->
        addrDataOe && addrDataOut == addrHiOut[7:0]) else $error("page address phase wrong");
    burst_split_a: assert property (addrLatchStrobe && cfgMode == mbi_pkg::MODE_BURST |->
        addrDataOut == {addrHiOut[3:0], addrLoOut[7:4]} && portAOe && portAOut[3:0] == addrLoOut[3:0])
        else $error("burst address split wrong");
    nonmux_noale_a: assert property (take && cfgMode == mbi_pkg::MODE_NONMUX |=> !addrLatchStrobe[*6])
        else $error("latch strobe on plain bus");
    rd_width_a: assert property (sep && $fell(readCtrlPin) |-> !readCtrlPin[*3] ##1 readCtrlPin)
        else $error("read strobe width");
    wr_data_a: assert property (sep && $fell(writeCtrlPin) |-> (!writeCtrlPin &&
        (cfgMode == mbi_pkg::MODE_NONMUX ? portAOe : addrDataOe))[*3] ##1 writeCtrlPin)
        else $error("write strobe or data drive");
    single_rd_a: assert property (take && cfgSingleRead |=> fetchCtrlPin[*6])
        else $error("fetch pin used with single read");
    e_width_a: assert property (cfgMoto && $rose(readCtrlPin) |-> readCtrlPin[*3] ##1 !readCtrlPin)
        else $error("enable strobe width");
    // main scenarios reached
    cover property (take && cfgMode == mbi_pkg::MODE_PAGE);
    cover property (take && cfgMode == mbi_pkg::MODE_BURST);
    cover property (take && cfgMoto);
endmodule
bind mbi_host_ctrl mbi_chk u_chk (.mclk, .rstn, .cfgMode, .cfgMoto, .cfgSingleRead, .reqValid, .reqReady,
    .rspValid, .addrDataOut, .addrDataOe, .portAOut, .portAOe, .addrLoOut, .addrHiOut, .addrLatchStrobe,
    .writeCtrlPin, .readCtrlPin, .fetchCtrlPin);

// ---- verif/mbi_dev_model.sv ----
/* device model: latches the address, stores written bytes, answers reads.
   assumes its mode and strobe style match the controller's cfg inputs. */
`timescale 1ns/1ps
module mbi_dev (
    // idle pattern clock and device setup
    input wire logic               mclk,
    input wire mbi_pkg::mbi_mode_e mode,
    input wire logic               moto,
    // host pins
    input wire logic [7:0]         addrDataOut,
    input wire logic               addrDataOe,
    input wire logic [7:0]         portAOut,
    input wire logic               portAOe,
    input wire logic [7:0]         addrLoOut,
    input wire logic [11:0]        addrHiOut,
    input wire logic               addrLatchStrobe,
    input wire logic               writeCtrlPin,
    input wire logic               readCtrlPin,
    input wire logic               fetchCtrlPin,
    // wire levels seen by the host
    output logic [7:0]             addrDataIn,
    output logic [7:0]             portAIn
);
    logic [7:0]  mem [int];
    logic [7:0]  latchAd;
    logic [7:0]  idlePat = 8'h5a;
    logic [7:0]  rdByte;
    logic        drive;
    logic [19:0] addr;
    wire logic   rdOn = moto ? (readCtrlPin && writeCtrlPin) : (!readCtrlPin || !fetchCtrlPin);
    wire logic   nm = (mode == mbi_pkg::MODE_NONMUX);
    wire logic [7:0] wrData = nm ? portAOut : addrDataOut;
    // address held from the strobe's falling edge
    always @(negedge addrLatchStrobe) latchAd = addrDataOut;
    // access address rebuilt per bus style
    always_comb begin
        case (mode)
            mbi_pkg::MODE_MUX:    addr = {addrHiOut, latchAd};
            mbi_pkg::MODE_PAGE:   addr = {addrHiOut[11:8], latchAd, addrLoOut};
            mbi_pkg::MODE_NONMUX: addr = {addrHiOut, addrDataOut};
            default:              addr = {addrHiOut[11:4], latchAd, portAOut[3:0]};
        endcase
    end
    // byte stored at the trailing edge of the write strobe, keyed by full address
    always @(posedge writeCtrlPin) if (!moto && !$isunknown(addr)) mem[addr] = wrData;
    always @(negedge readCtrlPin) if (moto && !writeCtrlPin) mem[addr] = wrData;
    // read data follows the strobe one clock late; free lines wander
    always @(posedge mclk) begin
        idlePat <= idlePat + 8'h3b;
        drive <= rdOn;
        rdByte <= mem.exists(addr) ? mem[addr] : addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]};
    end
    assign addrDataIn = addrDataOe ? addrDataOut : (drive && !nm) ? rdByte : idlePat;
    assign portAIn = portAOe ? portAOut : (drive && nm) ? rdByte : ~idlePat;
endmodule

// ---- verif/tb.sv ----
/* self-checking bench: random orders in every bus style against the device model.
   assumes model and controller share one mode setting. */
`timescale 1ns/1ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t %s", $time, m); end end
module tb;
    logic               mclk, rstn, cfgMoto, cfgSingleRead, reqValid, reqWrite, reqFetch;
    logic               reqReady, rspValid, addrDataOe, portAOe, addrLatchStrobe;
    logic               writeCtrlPin, readCtrlPin, fetchCtrlPin;
    logic [19:0]        reqAddr, lastTag [4];
    logic [11:0]        addrHiOut;
    logic [7:0]         reqWdata, rspRdata, addrDataIn, addrDataOut, portAIn, portAOut, addrLoOut;
    logic [7:0]         shadow [int];
    mbi_pkg::mbi_mode_e cfgMode;
    bit                 tagOk [4];
    int                 n_fail, comparisons, cyc;
    mbi_host_ctrl DUT (.mclk, .rstn, .cfgMode, .cfgMoto, .cfgSingleRead, .reqValid, .reqWrite, .reqFetch,
        .reqAddr, .reqWdata, .reqReady, .rspValid, .rspRdata, .addrDataIn, .addrDataOut, .addrDataOe, .portAIn,
        .portAOut, .portAOe, .addrLoOut, .addrHiOut, .addrLatchStrobe, .writeCtrlPin, .readCtrlPin, .fetchCtrlPin);
    mbi_dev u_dev (.mclk, .mode(cfgMode), .moto(cfgMoto), .addrDataOut, .addrDataOe, .portAOut, .portAOe,
        .addrLoOut, .addrHiOut, .addrLatchStrobe, .writeCtrlPin, .readCtrlPin, .fetchCtrlPin, .addrDataIn, .portAIn);
    // 10 MHz clock
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    // edges after the take edge until the answer shows: a latched cycle costs one more
    function automatic int lat(input logic [19:0] a);
        case (cfgMode)
            mbi_pkg::MODE_MUX:    return 6;
            mbi_pkg::MODE_NONMUX: return 5;
            mbi_pkg::MODE_PAGE:   return (tagOk[1] && lastTag[1][19:8] == a[19:8]) ? 5 : 6;
            default:              return (tagOk[3] && lastTag[3][19:4] == a[19:4]) ? 5 : 6;
        endcase
    endfunction
    function automatic logic [7:0] expb(input logic [19:0] a);
        if (shadow.exists(a)) return shadow[a];
        return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
    endfunction
    // one order; junk keeps a stray write request up for the first two busy cycles
    task automatic op(input logic w, input logic f, input logic [19:0] a, input logic [7:0] d, input bit junk);
        int n;
        int e;
        e = lat(a);
        n = 0;
        reqValid = 1; reqWrite = w; reqFetch = f; reqAddr = a; reqWdata = d;
        @(posedge mclk); #1;
        reqValid = junk; reqWrite = 1; reqAddr = a ^ 20'h0_0100;
        while (rspValid !== 1'b1 && n < 20) begin
            @(posedge mclk); #1;
            n++;
            if (n == 2) reqValid = 0;
        end
        `CHK(n, e, "answer latency")
        if (w) shadow[a] = d;
        else `CHK(rspRdata, expb(a), "read data")
        // any latched cycle replaces the one remembered address, whatever its mode
        if (e == 6) begin
            foreach (tagOk[i]) tagOk[i] = 0;
            lastTag[cfgMode] = a;
            tagOk[cfgMode] = 1;
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            $display("BAD %0t timeout", $time);
            give_verdict;
        end
    end
    initial begin
        logic [19:0] a;
        logic [7:0]  d;
        {rstn, reqValid, reqWrite, reqFetch, cfgMoto, cfgSingleRead} = 6'h00;
        reqAddr = 20'h0_0000;
        reqWdata = 8'h00;
        cfgMode = mbi_pkg::MODE_MUX;
        void'($urandom(88));
        repeat (8) @(posedge mclk);
        #1 `CHK({reqReady, rspValid, addrDataOe, portAOe, addrLatchStrobe, writeCtrlPin, readCtrlPin,
            fetchCtrlPin}, 8'h87, "reset levels")
        rstn = 1;
        for (int mo = 0; mo < 2; mo++) begin
            for (int m = 0; m < 4; m++) begin
                cfgMoto = mo[0];
                cfgMode = mbi_pkg::mbi_mode_e'(m[1:0]);
                cfgSingleRead = m[0];
                repeat (4) begin
                    a = 20'($urandom);
                    d = 8'($urandom);
                    op(1, 0, a, d, 1);
                    op(0, 0, a, 8'h00, 0);
                    op(0, 1, a ^ 20'h0_0001, 8'h00, 0);
                    op(0, 0, a ^ 20'h0_0100, 8'h00, 0);
                end
                $display("test mode %0d moto %0d done", m, mo);
            end
        end
        give_verdict;
    end
endmodule
